// ### hdl/pgc_pkg.sv
/*
 * pgc_pkg: register map, field positions, codes, carriers and states for
 * the packet generator and frame checker test block.
 * assumes: 16-bit registers, one aligned word per register index.
 */
package pgc_pkg;

    localparam int REG_W = 16;
    localparam int ADDR_W = 8;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_GEN = 8'h10;
    localparam logic [7:0] IDX_CNT = 8'h11;
    localparam logic [7:0] IDX_CHK = 8'h12;
    localparam logic [7:0] IDX_IPG = 8'h13;
    localparam logic [7:0] IDX_GCR = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_GEN = {IDX_GEN[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CNT = {IDX_CNT[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CHK = {IDX_CHK[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_IPG = {IDX_IPG[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_GCR = {IDX_GCR[5:0], 2'b00};

    // packet_generator_control fields
    localparam int GEN_BURST_HI = 15;
    localparam int GEN_BURST_LO = 8;
    localparam int GEN_EN_HI = 7;
    localparam int GEN_EN_LO = 5;
    localparam int GEN_TRIG = 4;
    localparam int GEN_HOLD = 3;
    localparam int GEN_PAT = 2;
    localparam int GEN_LONG = 1;
    localparam int GEN_ERR = 0;
    // frame_checker_control fields
    localparam int CHK_CLR = 4;
    localparam int CHK_SEL_HI = 2;
    // interframe_gap_length and general_control_one fields
    localparam int IPG_HI = 7;
    localparam int GCR_RST = 15;
    localparam int GCR_MODE_HI = 2;

    localparam logic [7:0] IPG_RESET = 8'h0C;
    localparam logic [2:0] GCR_RSV_VAL = 3'h4;

    // path codes shared by generator enable and checker select
    localparam logic [2:0] PATH_OFF = 3'h0;
    localparam logic [2:0] PATH_CU = 3'h2;
    localparam logic [2:0] PATH_SG = 3'h4;
    localparam logic [2:0] PATH_RG = 3'h6;

    // topology codes
    localparam logic [2:0] MODE_RG_CU = 3'h0;
    localparam logic [2:0] MODE_SG_CU = 3'h1;
    localparam logic [2:0] MODE_RG_BX = 3'h2;
    localparam logic [2:0] MODE_RG_FX = 3'h3;
    localparam logic [2:0] MODE_RG_SG = 3'h4;
    localparam logic [2:0] MODE_UNSET = 3'h7;

    // frame geometry, lengths include the check sequence
    localparam logic [10:0] LEN_SHORT = 11'h040;
    localparam logic [10:0] LEN_LONG = 11'h5EE;
    localparam int FCS_BYTES = 4;
    localparam logic [1:0] FCS_LAST = 2'h3;

    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
    localparam logic [7:0] PAT_A = 8'h5A;
    localparam logic [7:0] PAT_B = 8'hA5;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [7:0] IDLE_BYTE = 8'h00;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } pgc_rx_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic last;
        logic [7:0] data;
    } pgc_tx_t;

    typedef enum logic [1:0] {
        G_IDLE = 2'b00,
        G_DATA = 2'b01,
        G_FCS = 2'b11,
        G_GAP = 2'b10
    } pgc_gen_st_t;

endpackage : pgc_pkg

// ### hdl/pgc_crc_step.sv
/*
 * pgc_crc_step: one byte of reflected crc-32 update, combinational.
 * assumes: caller holds the running value and starts it at CRC_INIT.
 */
`timescale 1ns/1ps
module pgc_crc_step
    import pgc_pkg::*;
(
    input wire logic [31:0] crc_in,
    input wire logic [7:0] data,
    output logic [31:0] crc_out
);
    always_comb begin
        logic [31:0] c;
        c = crc_in ^ {24'h000000, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        crc_out = c;
    end
endmodule : pgc_crc_step

// ### hdl/pgc_sat_cnt.sv
/*
 * pgc_sat_cnt: up counter that holds at all ones.
 * assumes: clr and inc come from logic on clk.
 */
`timescale 1ns/1ps
module pgc_sat_cnt
    import pgc_pkg::*;
#(
    parameter int W = 8
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic inc,
    output logic [W-1:0] cnt
);
    logic [W-1:0] cnt_reg;
    wire logic at_max = &cnt_reg;
    wire logic [W-1:0] cnt_next = clr ? {{(W-1){1'b0}}, inc} :
        ((inc && !at_max) ? W'(cnt_reg + 1'b1) : cnt_reg);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    assign cnt = cnt_reg;
endmodule : pgc_sat_cnt

// ### hdl/pgc_top.sv
/*
 * pgc_top: packet generator, received frame checker with counters,
 * interframe gap and general control with software reset and topology.
 * assumes: register port and data streams are synchronous to clk.
 */
// Notes on behaviour
// - errored option sends bad check sequence plus symbol error flag
// - frame count in upper byte, saturates at 0xFF
// - check sequence error count in lower byte, saturates at 0xFF
// - writing one to counter reset clears counters, bit self-clears
// - checker select picks copper, sgmii or rgmii; others reserved
// - checker select zero disables and resets the checker
// - idle gap between frames is gap field plus one bytes
// - software reset bit resets the main state machines
// - software reset bit returns to zero when reset is done
// - software reset acts at once on generator and checker
// - three bit topology select encodes five system media pairings
// - new topology takes effect only at a software reset
// - topology reset value depends on product variant
// - generator enable picks output path, zero is normal operation
// - burst zero runs continuously, otherwise sends that many frames
// - trigger reads one when done; zero written then restarts
// - without hold bit, enable field clears after the burst
`timescale 1ns/1ps
module pgc_top
    import pgc_pkg::*;
#(
    parameter logic [2:0] MODE_RESET = MODE_RG_CU
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [REG_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [REG_W-1:0] reg_rdata,
    input wire pgc_rx_t rx_cu,
    input wire pgc_rx_t rx_sg,
    input wire pgc_rx_t rx_rg,
    output pgc_tx_t tx_out,
    output logic [2:0] tx_path,
    output logic [2:0] mode_active,
    output logic sm_reset
);

    ////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0] burst_reg;
    logic [2:0] gen_en_reg;
    logic done_reg;
    logic hold_reg;
    logic pat_reg;
    logic long_reg;
    logic err_reg;
    logic [2:0] chk_sel_reg;
    logic cnt_clr_reg;
    logic [7:0] ipg_reg;
    logic [2:0] mode_reg;
    logic [2:0] mode_act_reg;
    logic swrst_reg;
    logic [REG_W-1:0] rdata_reg;

    ////////////////////////////////////////////////////////////////////
    // generator state

    pgc_gen_st_t st_reg;
    pgc_gen_st_t st_next;
    logic [10:0] byte_cnt_reg;
    logic [10:0] byte_cnt_next;
    logic [1:0] fcs_idx_reg;
    logic [1:0] fcs_idx_next;
    logic [7:0] gap_cnt_reg;
    logic [7:0] gap_cnt_next;
    logic [7:0] left_reg;
    logic [7:0] left_next;
    logic [15:0] lfsr_reg;
    logic [15:0] lfsr_next;
    logic tgl_reg;
    logic tgl_next;
    logic [31:0] gcrc_reg;
    logic [31:0] gcrc_next;
    logic [31:0] gcrc_step;
    pgc_tx_t tx_reg;
    pgc_tx_t tx_next;
    logic [2:0] tx_path_reg;
    logic burst_end;

    ////////////////////////////////////////////////////////////////////
    // checker state

    logic [31:0] ccrc_reg;
    logic [31:0] ccrc_step;
    logic [7:0] pkt_cnt;
    logic [7:0] bad_cnt;

    ////////////////////////////////////////////////////////////////////
    // register decode

    wire logic wr_gen = reg_wr && (reg_addr == ADDR_GEN);
    wire logic wr_chk = reg_wr && (reg_addr == ADDR_CHK);
    wire logic wr_ipg = reg_wr && (reg_addr == ADDR_IPG);
    wire logic wr_gcr = reg_wr && (reg_addr == ADDR_GCR);
    wire logic [2:0] wr_en_field = reg_wdata[GEN_EN_HI:GEN_EN_LO];

    // restart on zero written while done
    wire logic trig_restart = wr_gen && !reg_wdata[GEN_TRIG] &&
        done_reg;
    wire logic en_start = wr_gen && (gen_en_reg == PATH_OFF) &&
        (wr_en_field != PATH_OFF);

    // burst end sets done even when cleared in the same cycle
    wire logic done_next = burst_end ? 1'b1 :
        ((trig_restart || en_start) ? 1'b0 : done_reg);
    wire logic [2:0] gen_en_next = wr_gen ? wr_en_field :
        ((burst_end && !hold_reg) ? PATH_OFF : gen_en_reg);

    wire logic swrst_next = wr_gcr && reg_wdata[GCR_RST];
    wire logic [2:0] mode_act_next = swrst_reg ? mode_reg :
        mode_act_reg;

    ////////////////////////////////////////////////////////////////////
    // read mux

    wire logic [REG_W-1:0] rd_gen = {burst_reg, gen_en_reg, done_reg,
        hold_reg, pat_reg, long_reg, err_reg};
    wire logic [REG_W-1:0] rd_cnt = {pkt_cnt, bad_cnt};
    wire logic [REG_W-1:0] rd_chk = {11'h000, cnt_clr_reg, 1'b0,
        chk_sel_reg};
    wire logic [REG_W-1:0] rd_ipg = {8'h00, ipg_reg};
    wire logic [REG_W-1:0] rd_gcr = {swrst_reg, 5'h00, GCR_RSV_VAL,
        4'h0, mode_reg};
    wire logic [REG_W-1:0] rd_val =
        (reg_addr == ADDR_GEN) ? rd_gen :
        (reg_addr == ADDR_CNT) ? rd_cnt :
        (reg_addr == ADDR_CHK) ? rd_chk :
        (reg_addr == ADDR_IPG) ? rd_ipg :
        (reg_addr == ADDR_GCR) ? rd_gcr : '0;
    wire logic [REG_W-1:0] rdata_next = reg_rd ? rd_val : '0;

    ////////////////////////////////////////////////////////////////////
    // register flops

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            burst_reg <= '0;
            gen_en_reg <= PATH_OFF;
            done_reg <= 1'b0;
            hold_reg <= 1'b0;
            pat_reg <= 1'b0;
            long_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            if (wr_gen) begin
                burst_reg <= reg_wdata[GEN_BURST_HI:GEN_BURST_LO];
                hold_reg <= reg_wdata[GEN_HOLD];
                pat_reg <= reg_wdata[GEN_PAT];
                long_reg <= reg_wdata[GEN_LONG];
                err_reg <= reg_wdata[GEN_ERR];
            end
            gen_en_reg <= gen_en_next;
            done_reg <= done_next;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chk_sel_reg <= PATH_OFF;
            cnt_clr_reg <= 1'b0;
            ipg_reg <= IPG_RESET;
        end else begin
            if (wr_chk) begin
                chk_sel_reg <= reg_wdata[CHK_SEL_HI:0];
            end
            cnt_clr_reg <= wr_chk && reg_wdata[CHK_CLR];
            if (wr_ipg) begin
                ipg_reg <= reg_wdata[IPG_HI:0];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= MODE_RESET;
            mode_act_reg <= MODE_RESET;
            swrst_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            if (wr_gcr) begin
                mode_reg <= reg_wdata[GCR_MODE_HI:0];
            end
            mode_act_reg <= mode_act_next;
            swrst_reg <= swrst_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // generator

    wire logic gen_path_ok = (gen_en_reg == PATH_CU) ||
        (gen_en_reg == PATH_SG) || (gen_en_reg == PATH_RG);
    wire logic [10:0] data_last = long_reg ?
        11'(LEN_LONG - FCS_BYTES - 1) : 11'(LEN_SHORT - FCS_BYTES - 1);
    wire logic [7:0] pay_byte = pat_reg ? (tgl_reg ? PAT_B : PAT_A) :
        lfsr_reg[7:0];
    // errored frames skip the final inversion
    wire logic [7:0] fcs_byte = err_reg ? gcrc_reg[7:0] :
        ~gcrc_reg[7:0];
    wire logic more = (burst_reg == 8'h00) || (left_reg != 8'h01);

    pgc_crc_step u_gen_crc (
        .crc_in(gcrc_reg),
        .data(pay_byte),
        .crc_out(gcrc_step)
    );

    always_comb begin
        st_next = st_reg;
        byte_cnt_next = byte_cnt_reg;
        fcs_idx_next = fcs_idx_reg;
        gap_cnt_next = gap_cnt_reg;
        left_next = left_reg;
        lfsr_next = lfsr_reg;
        tgl_next = tgl_reg;
        gcrc_next = gcrc_reg;
        tx_next = '{valid: 1'b0, err: 1'b0, last: 1'b0, data: IDLE_BYTE};
        burst_end = 1'b0;
        case (st_reg)
            G_IDLE: begin
                if (gen_path_ok && !done_reg) begin
                    st_next = G_DATA;
                    byte_cnt_next = '0;
                    left_next = burst_reg;
                    gcrc_next = CRC_INIT;
                end
            end
            G_DATA: begin
                tx_next = '{valid: 1'b1, err: 1'b0, last: 1'b0,
                    data: pay_byte};
                gcrc_next = gcrc_step;
                tgl_next = !tgl_reg;
                lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^
                    lfsr_reg[12] ^ lfsr_reg[10]};
                byte_cnt_next = 11'(byte_cnt_reg + 1'b1);
                if (byte_cnt_reg == data_last) begin
                    st_next = G_FCS;
                    fcs_idx_next = '0;
                end
            end
            G_FCS: begin
                tx_next = '{valid: 1'b1,
                    err: err_reg && (fcs_idx_reg == 2'h0),
                    last: fcs_idx_reg == FCS_LAST,
                    data: fcs_byte};
                gcrc_next = {8'h00, gcrc_reg[31:8]};
                fcs_idx_next = 2'(fcs_idx_reg + 1'b1);
                if (fcs_idx_reg == FCS_LAST) begin
                    st_next = G_GAP;
                    gap_cnt_next = ipg_reg;
                end
            end
            G_GAP: begin
                gap_cnt_next = 8'(gap_cnt_reg - 1'b1);
                if (gap_cnt_reg == 8'h00) begin
                    if (more) begin
                        st_next = G_DATA;
                        byte_cnt_next = '0;
                        gcrc_next = CRC_INIT;
                        if (burst_reg != 8'h00) begin
                            left_next = 8'(left_reg - 1'b1);
                        end
                    end else begin
                        st_next = G_IDLE;
                        burst_end = 1'b1;
                    end
                end
            end
            default: begin
                st_next = G_IDLE;
            end
        endcase
        if (!gen_path_ok && (st_reg != G_IDLE)) begin
            st_next = G_IDLE;
            burst_end = 1'b0;
        end
    end

    // soft reset idles the generator, keeps settings
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= G_IDLE;
            tx_reg <= '0;
            tx_path_reg <= PATH_OFF;
        end else if (swrst_reg) begin
            st_reg <= G_IDLE;
            tx_reg <= '0;
            tx_path_reg <= gen_en_reg;
        end else begin
            st_reg <= st_next;
            tx_reg <= tx_next;
            tx_path_reg <= gen_en_reg;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            byte_cnt_reg <= '0;
            fcs_idx_reg <= '0;
            gap_cnt_reg <= '0;
            left_reg <= '0;
            lfsr_reg <= LFSR_SEED;
            tgl_reg <= 1'b0;
            gcrc_reg <= CRC_INIT;
        end else begin
            byte_cnt_reg <= byte_cnt_next;
            fcs_idx_reg <= fcs_idx_next;
            gap_cnt_reg <= gap_cnt_next;
            left_reg <= left_next;
            lfsr_reg <= lfsr_next;
            tgl_reg <= tgl_next;
            gcrc_reg <= gcrc_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checker

    wire pgc_rx_t rx_sel = (chk_sel_reg == PATH_CU) ? rx_cu :
        (chk_sel_reg == PATH_SG) ? rx_sg :
        (chk_sel_reg == PATH_RG) ? rx_rg : '0;
    wire logic chk_off = chk_sel_reg == PATH_OFF;
    wire logic frame_end = rx_sel.valid && rx_sel.last && !swrst_reg;
    wire logic crc_bad = ccrc_step != CRC_RESIDUE;
    wire logic [31:0] ccrc_next = (chk_off || swrst_reg) ? CRC_INIT :
        (frame_end ? CRC_INIT :
        (rx_sel.valid ? ccrc_step : ccrc_reg));
    wire logic cnt_clr = cnt_clr_reg || chk_off;

    pgc_crc_step u_chk_crc (
        .crc_in(ccrc_reg),
        .data(rx_sel.data),
        .crc_out(ccrc_step)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ccrc_reg <= CRC_INIT;
        end else begin
            ccrc_reg <= ccrc_next;
        end
    end

    // counters ignore soft reset
    pgc_sat_cnt #(.W(8)) u_pkt_cnt (
        .clk(clk),
        .nrst(nrst),
        .clr(cnt_clr),
        .inc(frame_end),
        .cnt(pkt_cnt)
    );

    pgc_sat_cnt #(.W(8)) u_bad_cnt (
        .clk(clk),
        .nrst(nrst),
        .clr(cnt_clr),
        .inc(frame_end && crc_bad),
        .cnt(bad_cnt)
    );

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata = rdata_reg;
    assign tx_out = tx_reg;
    assign tx_path = tx_path_reg;
    assign mode_active = mode_act_reg;
    assign sm_reset = swrst_reg;

endmodule : pgc_top

// ### test/pgc_top_asserts.sv
/* pgc_top_asserts: port checks for pgc_top.
   assumes: one clock domain, bound into pgc_top. */
`timescale 1ns/1ps
module pgc_top_asserts
    import pgc_pkg::*;
(
    input logic clk,
    input logic nrst,
    input logic [ADDR_W-1:0] reg_addr,
    input logic [REG_W-1:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [REG_W-1:0] reg_rdata,
    input pgc_tx_t tx_out,
    input logic [2:0] tx_path,
    input logic [2:0] mode_active,
    input logic sm_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    logic rst_wr;
    assign rst_wr = reg_wr && reg_addr == ADDR_GCR && reg_wdata[GCR_RST];
    ////////////////////////////////////////////////////////////////////////
    AST_IPG_RW: assert property (
        reg_wr && reg_addr == ADDR_IPG ##1 reg_rd && reg_addr == ADDR_IPG
        |=> reg_rdata[IPG_HI:0] == $past(reg_wdata[IPG_HI:0], 2))
        else $error("gap readback wrong");
    AST_CLR_SC: assert property (
        reg_wr && reg_addr == ADDR_CHK && reg_wdata[CHK_CLR] ##2
        reg_rd && reg_addr == ADDR_CHK |=> !reg_rdata[CHK_CLR])
        else $error("counter clear stuck");
    AST_SWRST_PULSE: assert property (
        rst_wr |=> sm_reset ##1 !sm_reset)
        else $error("soft reset pulse wrong");
    AST_SWRST_CAUSE: assert property (
        $rose(sm_reset) |-> $past(rst_wr))
        else $error("soft reset without write");
    AST_MODE_TAKE: assert property (
        rst_wr |=> ##1 mode_active == $past(reg_wdata[2:0], 2))
        else $error("topology not taken");
    AST_MODE_HOLD: assert property (
        !sm_reset |=> $stable(mode_active))
        else $error("topology moved without reset");
    AST_SWRST_TX: assert property (
        sm_reset |=> !tx_out.valid)
        else $error("tx busy after soft reset");
    AST_SYM_ERR: assert property (
        tx_out.err |-> tx_out.valid && !tx_out.last ##1
        (tx_out.valid && !tx_out.err && !tx_out.last) [*2] ##1
        (tx_out.valid && tx_out.last))
        else $error("symbol error misplaced");
    AST_GAP_MIN: assert property (
        tx_out.last |=> !tx_out.valid)
        else $error("no gap after frame");
    AST_PATH_OFF: assert property (
        (tx_path == PATH_OFF) [*3] |-> !tx_out.valid)
        else $error("tx while generator off");
    cover property (sm_reset);
    cover property (tx_out.err);
    cover property (tx_out.last ##[1:20] tx_out.valid);
endmodule : pgc_top_asserts

bind pgc_top pgc_top_asserts u_chk (.*);

// ### test/pgc_link_model.sv
/* pgc_link_model: far side, feeds receive lines, checks tx frames.
   assumes: send called just after a clk edge. */
`timescale 1ns/1ps
module pgc_link_model
    import pgc_pkg::*;
(
    input logic clk,
    input pgc_tx_t tx_in,
    output pgc_rx_t rx_cu,
    output pgc_rx_t rx_sg,
    output pgc_rx_t rx_rg
);
    pgc_rx_t cur = '0;
    logic act = 1'b0;
    int pth = 0, len_c = 0, gap_c = 0;
    int tx_frames = 0, tx_bad = 0, tx_sym = 0, tx_len = 0, tx_gap = 0;
    logic [7:0] pat = 8'h00;
    logic [31:0] mc = CRC_INIT;
    function automatic logic [31:0] crc8(input logic [31:0] c,
        input logic [7:0] d);
        c = c ^ {24'h0, d};
        for (int k = 0; k < 8; k++) begin
            c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        return c;
    endfunction : crc8
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) pat <= pat + 8'h01;
    assign rx_cu = (act && pth == 0) ? cur : {2'b00, pat};
    assign rx_sg = (act && pth == 1) ? cur : {2'b00, pat};
    assign rx_rg = (act && pth == 2) ? cur : {2'b00, pat};
    task automatic send(input int p, input int n, input logic bad,
        input logic [31:0] s);
        logic [7:0] q[$];
        logic [31:0] c = CRC_INIT;
        for (int i = 0; i < n; i++) begin
            q.push_back(8'(s >> (i % 24)) ^ 8'(i));
            c = crc8(c, q[i]);
        end
        c = ~c ^ {31'h0, bad};
        for (int i = 0; i < FCS_BYTES; i++) begin
            q.push_back(c[8*i +: 8]);
        end
        pth <= p;
        foreach (q[i]) begin
            cur <= {1'b1, i == q.size() - 1, q[i]};
            act <= 1'b1;
            @(posedge clk);
        end
        act <= 1'b0;
        @(posedge clk);
    endtask : send
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (tx_in.valid) begin
            if (len_c == 0) begin
                tx_gap <= gap_c;
                mc = CRC_INIT;
            end
            mc = crc8(mc, tx_in.data);
            len_c = len_c + 1;
            gap_c = 0;
            if (tx_in.err) tx_sym <= tx_sym + 1;
            if (tx_in.last) begin
                tx_len <= len_c;
                tx_frames <= tx_frames + 1;
                if (mc != CRC_RESIDUE) tx_bad <= tx_bad + 1;
                len_c = 0;
            end
        end else begin
            gap_c = gap_c + 1;
        end
    end
endmodule : pgc_link_model

// ### test/packet_gen_crc_checker_tb.sv
/* packet_gen_crc_checker_tb: self-checking bench for pgc_top.
   assumes: all design and test files compiled first. */
`timescale 1ns/1ps
module packet_gen_crc_checker_tb
    import pgc_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [REG_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [REG_W-1:0] reg_rdata;
    pgc_rx_t rx_cu, rx_sg, rx_rg;
    pgc_tx_t tx_out;
    logic [2:0] tx_path, mode_active;
    logic sm_reset;
    int err_count = 0, tests_run = 0, n_frm = 0, n_bad = 0;
    logic [31:0] lfsr_reg = 32'hFA748A0A;
    logic [2:0] sels [4] = '{PATH_CU, PATH_SG, PATH_RG, 3'h5};
    pgc_top DUT (
        .clk(clk),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .rx_cu(rx_cu),
        .rx_sg(rx_sg),
        .rx_rg(rx_rg),
        .tx_out(tx_out),
        .tx_path(tx_path),
        .mode_active(mode_active),
        .sm_reset(sm_reset)
    );
    pgc_link_model LINK (
        .clk(clk),
        .tx_in(tx_out),
        .rx_cu(rx_cu),
        .rx_sg(rx_sg),
        .rx_rg(rx_rg)
    );
    always #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr_reg = {lfsr_reg[30:0],
            lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
        return lfsr_reg;
    endfunction : rnd
    task automatic chk(input string w, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        if (reg_wr) @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e, string w);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(w, e, reg_rdata);
        @(posedge clk);
    endtask : rd
    task automatic frame(input int p, input logic bad, input logic hit);
        LINK.send(p, 5 + int'(lfsr_reg[4:1]), bad, rnd());
        if (hit && n_frm < 255) n_frm++;
        if (hit && bad && n_bad < 255) n_bad++;
    endtask : frame
    task automatic sel_path(input logic [2:0] s);
        wr(ADDR_CHK, 16'h0000);
        wr(ADDR_CHK, {13'h0, s});
        n_frm = 0;
        n_bad = 0;
    endtask : sel_path
    task automatic wait_tx(input int n);
        int t = 0;
        while (LINK.tx_frames < n && t < 3000) begin
            @(posedge clk);
            t++;
        end
        chk("tx_frames", n, LINK.tx_frames);
    endtask : wait_tx
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        $display("[ERR] watchdog expected end seen hang");
        final_report();
    end
    initial begin
        logic [7:0] g;
        logic [15:0] v;
        int b;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(ADDR_GEN, 16'h0000, "gen_rst");
        rd(ADDR_IPG, 16'h000C, "ipg_rst");
        rd(ADDR_GCR, 16'h0200, "gcr_rst");
        wr(ADDR_CNT, 16'hFFFF);
        rd(ADDR_CNT, 16'h0000, "cnt_ro");
        rd(8'h00, 16'h0000, "unmapped");
        foreach (sels[s]) begin
            sel_path(sels[s]);
            for (int p = 0; p < 3; p++) begin
                frame(p, 1'(rnd()), sels[s] == 3'(2 * p + 2));
            end
            rd(ADDR_CNT, 16'(n_frm * 256 + n_bad), "cnt_sel");
        end
        sel_path(PATH_RG);
        repeat (257) frame(2, 1'b1, 1'b1);
        rd(ADDR_CNT, 16'(n_frm * 256 + n_bad), "cnt_sat");
        wr(ADDR_CHK, 16'h0016);
        @(posedge clk);
        rd(ADDR_CHK, 16'h0006, "clr_sc");
        rd(ADDR_CNT, 16'h0000, "cnt_clr");
        frame(2, 1'b0, 1'b1);
        rd(ADDR_CNT, 16'h0100, "cnt_one");
        g = 8'(rnd() % 8) + 8'h02;
        wr(ADDR_IPG, {8'h00, g});
        rd(ADDR_IPG, {8'h00, g}, "ipg");
        for (int i = 0; i < 3; i++) begin
            b = LINK.tx_frames;
            v = {8'h02, sels[i], 1'b0, 1'b1, i[0], 1'b0, i == 1};
            wr(ADDR_GEN, v);
            wait_tx(b + 2);
            repeat (20) @(posedge clk);
            chk("path", sels[i], tx_path);
            chk("len", LEN_SHORT, LINK.tx_len);
            chk("gap", g + 1, LINK.tx_gap);
            chk("fcs_bad", (i > 0) ? 2 : 0, LINK.tx_bad);
            chk("sym_err", (i > 0) ? 2 : 0, LINK.tx_sym);
            rd(ADDR_GEN, v | 16'h0010, "done");
        end
        b = LINK.tx_frames;
        wr(ADDR_GEN, 16'h0140);
        wait_tx(b + 1);
        repeat (20) @(posedge clk);
        rd(ADDR_GEN, 16'h0110, "self_clr");
        chk("path_off", PATH_OFF, tx_path);
        b = LINK.tx_frames;
        wr(ADDR_GEN, 16'h0040);
        wait_tx(b + 3);
        wr(ADDR_GCR, 16'h8000);
        repeat (30) @(posedge clk);
        wr(ADDR_GEN, 16'h0000);
        repeat (4) @(posedge clk);
        chk("tx_idle", 0, tx_out.valid);
        rd(ADDR_CNT, 16'h0100, "cnt_keep");
        rd(ADDR_IPG, {8'h00, g}, "ipg_keep");
        wr(ADDR_GCR, 16'h0003);
        repeat (3) @(posedge clk);
        chk("mode_wait", MODE_RG_CU, mode_active);
        for (int m = 4; m >= 0; m--) begin
            wr(ADDR_GCR, 16'h8000 | 16'(m));
            @(negedge clk);
            chk("sm_reset", 1, sm_reset);
            @(negedge clk);
            chk("sm_done", 0, sm_reset);
            chk("mode", m, mode_active);
            @(posedge clk);
            rd(ADDR_GCR, 16'h0200 | 16'(m), "gcr");
        end
        sel_path(PATH_RG);
        rd(ADDR_CNT, 16'h0000, "cnt_off");
        final_report();
    end
endmodule : packet_gen_crc_checker_tb
